// ### rtl/itd_pkg.sv
// Constants and types shared by the instruction timing decoder
package itd_pkg;
	// ==========================================================
	// Instruction word layout
	localparam int INSTR_W = 13;
	localparam int REG_LSB = 0;
	localparam int REG_W = 6;
	localparam int BIT_LSB = 6;
	localparam int BIT_W = 3;
	localparam int LIT_W = 10;
	localparam int LIT_SHORT_W = 8;
	localparam logic [5:0] PC_REG_ADDR = 6'h02;

	// ==========================================================
	// Fixed encodings
	localparam logic [12:0] OP_NOP = 13'h0000;
	localparam logic [12:0] OP_SLEEP = 13'h0002;
	localparam logic [12:0] OP_WDT_CLEAR = 13'h0004;
	localparam logic [12:0] OP_IRQ_ON = 13'h0010;
	localparam logic [12:0] OP_IRQ_OFF = 13'h0011;
	localparam logic [12:0] OP_RETURN = 13'h0012;
	localparam logic [12:0] OP_RETURN_IRQ = 13'h0013;
	localparam logic [5:0] GRP_MOV_R_A = 6'h01;
	localparam logic [5:0] GRP_CLR_R = 6'h03;
	localparam logic [2:0] GRP_BIT_CLEAR = 3'h4;
	localparam logic [2:0] GRP_BIT_SET = 3'h5;
	localparam logic [2:0] GRP_SKIP_CLEAR = 3'h6;
	localparam logic [2:0] GRP_SKIP_SET = 3'h7;
	localparam logic [3:0] GRP_DECR_SKIP = 4'h5;
	localparam logic [3:0] GRP_INCR_SKIP = 4'h7;
	localparam logic [1:0] GRP_CALL = 2'h0;
	localparam logic [1:0] GRP_JUMP = 2'h1;
	localparam logic [3:0] GRP_RETURN_LIT = 4'hC;

	// ==========================================================
	// Configuration word and cycle timing
	localparam int CFG_PERIOD_BIT = 8;
	localparam int CFG_JUMP_BIT = 6;
	localparam logic [2:0] PERIOD_SHORT = 3'h2;
	localparam logic [2:0] PERIOD_LONG = 3'h4;
	localparam logic [1:0] PHASE_LAST_SHORT = 2'(PERIOD_SHORT - 3'h1);
	localparam logic [1:0] PHASE_LAST_LONG = 2'(PERIOD_LONG - 3'h1);

	typedef enum logic [2:0] {ST_NOP, ST_EXEC, ST_SECOND, ST_SLEEP} itd_state_e;
endpackage

// ### rtl/itd_cycle_timer.sv
// Oscillator phase counter giving instruction cycle ends and timer ticks
`timescale 1ns/100ps
module itd_cycle_timer
	import itd_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic run,
	input wire logic fourPeriod,
	output logic cycleLast,
	output logic timerTick
);
	logic [1:0] phase;
	logic [1:0] lastPhase;

	assign lastPhase = fourPeriod ? PHASE_LAST_LONG : PHASE_LAST_SHORT;
	assign cycleLast = run && (phase == lastPhase);

	// ==========================================================
	// Phase counter, frozen while the oscillator is stopped
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			phase <= 2'h0;
		end else if (cycleLast) begin
			phase <= 2'h0;
		end else if (run) begin
			phase <= phase + 2'h1;
		end
	end

	// Timer clock runs at the instruction cycle rate
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timerTick <= 1'b0;
		end else begin
			timerTick <= cycleLast;
		end
	end

	// ==========================================================
	// Checks
	property p_short_cycle;
		@(posedge clock) disable iff (!rst_n)
		(!fourPeriod && cycleLast) ##1 run [*2] |-> cycleLast;
	endproperty
	a_short_cycle: assert property (p_short_cycle) else $error("short cycle not 2 clocks");

	property p_long_tick;
		@(posedge clock) disable iff (!rst_n)
		(fourPeriod && timerTick && run) ##1 run [*3] |=> timerTick;
	endproperty
	a_long_tick: assert property (p_long_tick) else $error("timer tick not every 4 clocks");

	property p_long_gap;
		@(posedge clock) disable iff (!rst_n)
		(fourPeriod && cycleLast) |=> !cycleLast [*3];
	endproperty
	a_long_gap: assert property (p_long_gap) else $error("long cycle shorter than 4 clocks");
endmodule

// ### rtl/itd_core.sv
// Instruction fetch, decode and cycle sequencing for the 8-bit core
`timescale 1ns/100ps
module itd_core
	import itd_pkg::*;
#(
	parameter int INSTR_WIDTH = 13
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [12:0] configWord,
	input wire logic [12:0] instrWord,
	input wire logic bitValue,
	input wire logic resultZero,
	input wire logic wakeUp,
	output logic fetchStrobe,
	output logic commitStrobe,
	output logic secondCycle,
	output logic [5:0] regAddr,
	output logic [2:0] bitSel,
	output logic [9:0] literal,
	output logic [6:0] opField,
	output logic regWrite,
	output logic bitSetOp,
	output logic bitClearOp,
	output logic bitTestOp,
	output logic pcRegWrite,
	output logic jumpOp,
	output logic callOp,
	output logic returnOp,
	output logic returnLitOp,
	output logic setGie,
	output logic clearGie,
	output logic wdtClear,
	output logic sleepFlagUpdate,
	output logic oscStop,
	output logic timerTick
);
	if (INSTR_WIDTH != INSTR_W) begin : g_bad_width
		$error("itd_core serves only 13-bit instruction words");
	end

	itd_state_e state;
	logic cfgLoaded;
	logic periodOpt;
	logic jumpOpt;
	logic cycleLast;
	logic run;
	logic fetch;
	logic loadReal;
	logic twoCyc;
	logic skipOp;
	logic skipOnSet;
	logic skipOnClear;
	logic sleepOp;
	logic wdtOp;
	logic skipHit;
	logic dMovRA, dClr, dAlu, dBitClr, dBitSet, dSkipClr, dSkipSet, dSkipZero;
	logic dRegWrite, dPcTarget, dCall, dJump, dRet, dReti, dRetl, dSkip, dTwo;

	// ==========================================================
	// Option capture after reset release
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfgLoaded <= 1'b0;
			periodOpt <= 1'b0;
			jumpOpt <= 1'b0;
		end else if (!cfgLoaded) begin
			cfgLoaded <= 1'b1;
			periodOpt <= configWord[CFG_PERIOD_BIT];
			jumpOpt <= configWord[CFG_JUMP_BIT];
		end
	end

	assign run = cfgLoaded && (state != ST_SLEEP);

	itd_cycle_timer u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.run(run),
		.fourPeriod(periodOpt),
		.cycleLast(cycleLast),
		.timerTick(timerTick)
	);

	// ==========================================================
	// Decode of the word on the program memory bus
	always_comb begin
		dMovRA = !instrWord[12] && (instrWord[11:6] == GRP_MOV_R_A);
		dClr = !instrWord[12] && (instrWord[11:6] == GRP_CLR_R);
		dAlu = !instrWord[12] && !instrWord[11] && (instrWord[11:8] != 4'h0);
		dBitClr = !instrWord[12] && (instrWord[11:9] == GRP_BIT_CLEAR);
		dBitSet = !instrWord[12] && (instrWord[11:9] == GRP_BIT_SET);
		dSkipClr = !instrWord[12] && (instrWord[11:9] == GRP_SKIP_CLEAR);
		dSkipSet = !instrWord[12] && (instrWord[11:9] == GRP_SKIP_SET);
		dSkipZero = !instrWord[12] && instrWord[7]
			&& ((instrWord[11:8] == GRP_DECR_SKIP) || (instrWord[11:8] == GRP_INCR_SKIP));
		// Port registers share the plain register address space
		dRegWrite = dMovRA || dClr || (dAlu && instrWord[6]) || dBitClr || dBitSet;
		dPcTarget = dRegWrite && (instrWord[5:0] == PC_REG_ADDR);
		dCall = instrWord[12] && (instrWord[11:10] == GRP_CALL);
		dJump = instrWord[12] && (instrWord[11:10] == GRP_JUMP);
		dRet = instrWord == OP_RETURN;
		dReti = instrWord == OP_RETURN_IRQ;
		dRetl = instrWord[12] && (instrWord[11:8] == GRP_RETURN_LIT);
		dSkip = dSkipClr || dSkipSet || dSkipZero;
		dTwo = dPcTarget || dRet || dReti || dRetl || dSkip
			|| ((dCall || dJump) && jumpOpt);
	end

	// ==========================================================
	// Fetch points: end of a one-cycle instruction other than sleep, a second cycle or a no-op
	always_comb begin
		fetch = cycleLast && ((state == ST_NOP) || (state == ST_SECOND)
			|| ((state == ST_EXEC) && !twoCyc && !sleepOp));
		loadReal = fetch && !((state == ST_SECOND) && skipOp && skipHit);
	end

	// Instruction register fields, cleared to a no-op on discard
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			regAddr <= 6'h00;
			bitSel <= 3'h0;
			literal <= 10'h000;
			opField <= 7'h00;
		end else if (loadReal) begin
			regAddr <= instrWord[REG_LSB +: REG_W];
			bitSel <= instrWord[BIT_LSB +: BIT_W];
			literal <= (dCall || dJump) ? instrWord[LIT_W-1:0]
				: {2'h0, instrWord[LIT_SHORT_W-1:0]};
			opField <= instrWord[12:6];
		end else if (fetch) begin
			regAddr <= 6'h00;
			bitSel <= 3'h0;
			literal <= 10'h000;
			opField <= OP_NOP[12:6];
		end
	end

	// Decoded operation class
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			{regWrite, bitSetOp, bitClearOp, bitTestOp, pcRegWrite} <= 5'h00;
			{jumpOp, callOp, returnOp, returnLitOp, setGie, clearGie} <= 6'h00;
			{twoCyc, skipOp, skipOnSet, skipOnClear, sleepOp, wdtOp} <= 6'h00;
		end else if (fetch) begin
			regWrite <= loadReal && dRegWrite;
			bitSetOp <= loadReal && dBitSet;
			bitClearOp <= loadReal && dBitClr;
			bitTestOp <= loadReal && (dSkipClr || dSkipSet);
			pcRegWrite <= loadReal && dPcTarget;
			jumpOp <= loadReal && dJump;
			callOp <= loadReal && dCall;
			returnOp <= loadReal && (dRet || dReti || dRetl);
			returnLitOp <= loadReal && dRetl;
			setGie <= loadReal && (dReti || (instrWord == OP_IRQ_ON));
			clearGie <= loadReal && (instrWord == OP_IRQ_OFF);
			twoCyc <= loadReal && dTwo;
			skipOp <= loadReal && dSkip;
			skipOnSet <= dSkipSet;
			skipOnClear <= dSkipClr;
			sleepOp <= loadReal && (instrWord == OP_SLEEP);
			wdtOp <= loadReal && (instrWord == OP_WDT_CLEAR);
		end
	end

	// ==========================================================
	// Skip condition, judged at the end of the first cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			skipHit <= 1'b0;
		end else if (cycleLast && (state == ST_EXEC)) begin
			skipHit <= skipOnSet ? bitValue : (skipOnClear ? !bitValue : resultZero);
		end
	end

	// Cycle sequencer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= ST_NOP;
		end else begin
			case (state)
				ST_NOP: begin
					if (cycleLast) begin
						state <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (cycleLast) begin
						if (twoCyc) begin
							state <= ST_SECOND;
						end else if (sleepOp) begin
							state <= ST_SLEEP;
						end
					end
				end
				ST_SECOND: begin
					if (cycleLast) begin
						state <= (skipOp && skipHit) ? ST_NOP : ST_EXEC;
					end
				end
				ST_SLEEP: begin
					if (wakeUp) begin
						state <= ST_NOP;
					end
				end
				default: state <= ST_NOP;
			endcase
		end
	end

	// ==========================================================
	// Strobes and sleep control
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fetchStrobe <= 1'b0;
			commitStrobe <= 1'b0;
			secondCycle <= 1'b0;
			wdtClear <= 1'b0;
			sleepFlagUpdate <= 1'b0;
			oscStop <= 1'b0;
		end else begin
			fetchStrobe <= fetch;
			commitStrobe <= cycleLast && (((state == ST_EXEC) && !twoCyc)
				|| (state == ST_SECOND));
			secondCycle <= (state == ST_EXEC) && cycleLast && twoCyc;
			wdtClear <= cycleLast && (state == ST_EXEC) && (sleepOp || wdtOp);
			sleepFlagUpdate <= cycleLast && (state == ST_EXEC) && (sleepOp || wdtOp);
			if (cycleLast && (state == ST_EXEC) && sleepOp) begin
				oscStop <= 1'b1;
			end else if (wakeUp) begin
				oscStop <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_take(logic [12:0] w);
		loadReal && (instrWord == w);
	endsequence

	sequence s_skipTaken;
		(state == ST_SECOND) && cycleLast && skipOp && skipHit;
	endsequence

	property p_fields;
		loadReal |=> (regAddr == $past(instrWord[5:0])) && (bitSel == $past(instrWord[8:6]));
	endproperty
	a_fields: assert property (p_fields) else $error("operand fields not taken");

	property p_return;
		s_take(OP_RETURN) |=> returnOp && twoCyc && !setGie;
	endproperty
	a_return: assert property (p_return) else $error("return not decoded");

	property p_return_irq;
		s_take(OP_RETURN_IRQ) |=> returnOp && setGie && twoCyc;
	endproperty
	a_return_irq: assert property (p_return_irq) else $error("irq return not decoded");

	property p_pc_two;
		(state == ST_EXEC) && cycleLast && pcRegWrite |=> (state == ST_SECOND) && secondCycle;
	endproperty
	a_pc_two: assert property (p_pc_two) else $error("pc write not two cycles");

	property p_sleep;
		(state == ST_EXEC) && cycleLast && sleepOp |=> oscStop && wdtClear && sleepFlagUpdate
			&& (state == ST_SLEEP);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep effects missing");

	property p_skip_flush;
		s_skipTaken |=> (state == ST_NOP) && fetchStrobe && !regWrite && !pcRegWrite
			&& (opField == OP_NOP[12:6]);
	endproperty
	a_skip_flush: assert property (p_skip_flush) else $error("skipped word not dropped");

	property p_jump_one;
		loadReal && !jumpOpt && instrWord[12] && (instrWord[11:10] == GRP_JUMP) |=> !twoCyc && jumpOp;
	endproperty
	a_jump_one: assert property (p_jump_one) else $error("jump option ignored");

	property p_cfg_hold;
		cfgLoaded |=> $stable(periodOpt) && $stable(jumpOpt);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("option bits changed");

	property p_port_write;
		loadReal && !instrWord[12] && (instrWord[11:6] == GRP_MOV_R_A) |=> regWrite;
	endproperty
	a_port_write: assert property (p_port_write) else $error("register move lost");
endmodule

// ### bench/itd_prog_mem.sv
// Program memory model handing instruction words to the core
`timescale 1ns/100ps
module itd_prog_mem (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic fetchStrobe,
	input wire logic [12:0] prog [0:31],
	output logic [12:0] instrWord
);
	// ==========================================================
	// Sequential word pointer, moves once per fetch strobe, dropped words included
	logic [4:0] addr;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			addr <= 5'h00;
		end else if (fetchStrobe) begin
			addr <= addr + 5'h01;
		end
	end
	// Word always valid, as the core may sample on any cycle end
	assign instrWord = prog[addr];
endmodule

// ### bench/mcu_instruction_timing_decode_tb.sv
// Self-checking bench for the instruction timing decoder
`timescale 1ns/100ps
module mcu_instruction_timing_decode_tb;
	import itd_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [12:0] configWord = 13'h0000;
	logic bitValue = 1'b0;
	logic resultZero = 1'b0;
	logic wakeUp = 1'b0;
	logic [12:0] instrWord;
	logic fetchStrobe, commitStrobe, secondCycle, regWrite, bitSetOp, bitClearOp, bitTestOp;
	logic pcRegWrite, jumpOp, callOp, returnOp, returnLitOp, setGie, clearGie;
	logic wdtClear, sleepFlagUpdate, oscStop, timerTick;
	logic [5:0] regAddr;
	logic [2:0] bitSel;
	logic [9:0] literal;
	logic [6:0] opField;
	logic [12:0] prog [0:31];
	logic [12:0] q [$];
	logic [12:0] cur, nw;
	logic cb, cz, disc, stopPrev, slept;
	int miscompares = 0;
	int num_checks = 0;
	int seed = 32'h296a;
	int cyc = 0;
	int per = 2;
	int prevF, lastTick, nFetch, i;
	bit jtwo = 1'b0;

	always #10 clock = ~clock;

	itd_prog_mem mem (.clock(clock), .rst_n(rst_n), .fetchStrobe(fetchStrobe), .prog(prog),
		.instrWord(instrWord));

	itd_core dut (.clock(clock), .rst_n(rst_n), .configWord(configWord), .instrWord(instrWord),
		.bitValue(bitValue), .resultZero(resultZero), .wakeUp(wakeUp),
		.fetchStrobe(fetchStrobe), .commitStrobe(commitStrobe), .secondCycle(secondCycle),
		.regAddr(regAddr), .bitSel(bitSel), .literal(literal), .opField(opField),
		.regWrite(regWrite), .bitSetOp(bitSetOp), .bitClearOp(bitClearOp),
		.bitTestOp(bitTestOp), .pcRegWrite(pcRegWrite), .jumpOp(jumpOp), .callOp(callOp),
		.returnOp(returnOp), .returnLitOp(returnLitOp), .setGie(setGie), .clearGie(clearGie),
		.wdtClear(wdtClear), .sleepFlagUpdate(sleepFlagUpdate), .oscStop(oscStop),
		.timerTick(timerTick));

	// ==========================================================
	// Reference model helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic end_sim();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	function automatic bit incDec(input logic [12:0] w);
		return (w[12:8] == 5'h05 || w[12:8] == 5'h07) && w[7];
	endfunction

	function automatic bit rw(input logic [12:0] w);
		return w[12:6] == 7'h01 || w[12:6] == 7'h03 || w[12:10] == 3'h2
			|| (w[12:11] == 2'h0 && w[10:8] != 3'h0 && w[6]);
	endfunction

	function automatic bit pcw(input logic [12:0] w);
		return w[5:0] == 6'h02 && rw(w);
	endfunction

	function automatic int ncyc(input logic [12:0] w);
		return (w[12:10] == 3'h3 || incDec(w) || w == 13'h0012 || w == 13'h0013
			|| w[12:8] == 5'h1C || (w[12:11] == 2'h2 && jtwo) || pcw(w)) ? 2 : 1;
	endfunction

	function automatic logic [9:0] cls(input logic [12:0] w);
		return {w[12:10] == 3'h5, w[12:10] == 3'h4,
			w == 13'h0012 || w == 13'h0013 || w[12:8] == 5'h1C, w[12:8] == 5'h1C,
			w == 13'h0013 || w == 13'h0010, w == 13'h0011, w[12:9] == 4'h5,
			w[12:9] == 4'h4, w[12:10] == 3'h3, pcw(w)};
	endfunction

	// ==========================================================
	// Monitor comparing every fetch, commit and tick with the model
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			end_sim();
		end
		if (!rst_n) begin
			q = {};
			for (int k = 0; k < 32; k++) q.push_back(prog[k]);
			cur = 13'h0000;
			disc = 1'b0;
			prevF = -1;
			lastTick = -1;
			slept = 1'b0;
		end else begin
			if (oscStop && !slept) begin
				chk(32'({wdtClear, sleepFlagUpdate}), 32'h3);
				slept = 1'b1;
			end
			if (!oscStop) slept = 1'b0;
			if (oscStop && stopPrev) begin
				chk(32'({fetchStrobe, timerTick}), 32'h0);
				prevF = -1;
				lastTick = -1;
			end
			if (timerTick && !oscStop) begin
				if (lastTick >= 0) chk(32'(cyc - lastTick), 32'(per));
				lastTick = cyc;
			end
			if (commitStrobe) begin
				chk(32'(wdtClear), 32'(cur == 13'h0004 || cur == 13'h0002));
			end
			if (secondCycle) chk(32'(ncyc(cur)), 32'h2);
			if (fetchStrobe && !oscStop) begin
				if (prevF >= 0) chk(32'(cyc - prevF), 32'(per * ncyc(cur)));
				// Word after a taken skip is the one dropped
				disc = (cur[12:10] == 3'h3 && (cur[9] ? cb : !cb)) || (incDec(cur) && cz);
				nw = q.pop_front();
				if (disc) nw = 13'h0000;
				chk(32'(opField), 32'(nw[12:6]));
				chk(32'(regWrite), 32'(rw(nw)));
				chk(32'(regAddr), 32'(nw[5:0]));
				chk(32'(bitSel), 32'(nw[8:6]));
				chk(32'(literal), nw[12:11] == 2'h2 ? 32'(nw[9:0]) : 32'(nw[7:0]));
				chk(32'({jumpOp, callOp, returnOp, returnLitOp, setGie, clearGie, bitSetOp,
					bitClearOp, bitTestOp, pcRegWrite}), 32'(cls(nw)));
				cur = nw;
				cb = 1'($random(seed));
				cz = 1'($random(seed));
				bitValue <= cb;
				resultZero <= cz;
				prevF = cyc;
				nFetch++;
			end
		end
		stopPrev = oscStop;
	end

	// ==========================================================
	// Main sequence over both period and jump options
	initial begin
		prog = '{13'h0000, 13'h0010, 13'h0011, 13'h0145, 13'h0042, 13'h08C6, 13'h0D47,
			13'h0E05, 13'h05C9, 13'h0589, 13'h07C9, 13'h0789, 13'h12AB, 13'h1555, 13'h00C2,
			13'h0142, 13'h0B82, 13'h1C5A, 13'h0012, 13'h0013, 13'h0004, 13'h0002,
			13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000,
			13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000};
		nFetch = 0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clock);
			rst_n <= 1'b0;
			configWord <= {4'h0, k[0], 1'b0, k[1], 6'h00};
			repeat (6) @(posedge clock);
			// Model timing switched only while the monitor is in reset
			per = k[0] ? 4 : 2;
			jtwo = k[1];
			rst_n <= 1'b1;
			repeat (3) @(posedge clock);
			configWord <= 13'($random(seed));
			for (i = 0; i < 3000 && oscStop !== 1'b1; i++) @(posedge clock);
			chk(32'(oscStop), 32'h1);
			repeat (8) @(posedge clock);
			i = nFetch;
			wakeUp <= 1'b1;
			@(posedge clock);
			wakeUp <= 1'b0;
			repeat (2) @(posedge clock);
			#1 chk(32'(oscStop), 32'h0);
			// Short enough to stay inside the 32-word program
			repeat (8) @(posedge clock);
			chk(32'(nFetch > i), 32'h1);
		end
		end_sim();
	end
endmodule
